/* rtl/boot_init_pkg.sv */
// Purpose: constants and carrier types for the bootstrap initialization control
// Assumes: core clock of 100 MHz, association registers reached through the device register port
// Notes: association layout is seven low-side enables per high-side driver
package boot_init_pkg;

  localparam int NUM_HS = 5;
  localparam int NUM_LS = 7;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_ASSOC_12 = 10'h1a6;
  localparam logic [ADDR_W-1:0] ADDR_ASSOC_34 = 10'h1a7;
  localparam logic [ADDR_W-1:0] ADDR_ASSOC_5  = 10'h1a8;

  localparam logic [DATA_W-1:0] MASK_ASSOC_PAIR = 16'h7f7f;
  localparam logic [DATA_W-1:0] MASK_ASSOC_ONE  = 16'h007f;
  localparam logic [DATA_W-1:0] RST_ASSOC_PAIR  = 16'h7f7f;
  localparam logic [DATA_W-1:0] RST_ASSOC_ONE   = 16'h007f;
  localparam int                ASSOC_HI_LSB    = 8;

  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SRC_WIN_MS  = 36;
  localparam int SRC_WIN_CYC   = (T_SRC_WIN_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WIN_CNT_W     = 23;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h1,
    ST_INIT = 3'h2,
    ST_DONE = 3'h4
  } init_state_t;

  // per-driver analog comparator results
  typedef struct packed {
    logic [NUM_HS-1:0] boot_near_supply;
    logic [NUM_HS-1:0] clamp_active;
    logic [NUM_HS-1:0] src_below_0v5;
    logic [NUM_HS-1:0] src_below_1v0;
  } drv_sense_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

endpackage

/* rtl/bootstrap_init_control.sv */
// Purpose: bootstrap initialization and inhibit control for five high-side pre-drivers
// Assumes: all inputs synchronous to I_CLK_SYS; analog comparators already filtered
// Notes: outputs registered, one clock behind their inputs; init-phase outputs trail supply rise and termination by two clocks
`timescale 1ns/1ns
module bootstrap_init_control
  import boot_init_pkg::*;
#(
  parameter int WIN_CYC = SRC_WIN_CYC
) (
  input  wire logic              I_CLK_SYS,                // core clock
  input  wire logic              I_RST,                    // async reset, active high
  input  wire logic              I_SUPPLY_UV_OK,           // gate supply above rise threshold
  input  wire drv_sense_t        I_SENSE,                  // per-driver comparators
  input  wire logic [NUM_LS-1:0] I_LS_ON,                  // low-side drivers switched on
  input  wire logic [NUM_HS-1:0] I_HS_ON,                  // high-side drivers switched on
  input  wire logic [NUM_HS-1:0] I_INJ_END,                // end-of-injection window per driver
  input  wire logic [NUM_LS-1:0] I_LS_BIAS_REQ,            // normal low-side bias request
  input  wire logic [NUM_HS-1:0] I_HS_BIAS_REQ,            // normal high-side bias request
  input  wire reg_req_t          I_REG,                    // register port request
  output logic      [DATA_W-1:0] O_REG_RDATA,              // register read data
  output logic      [NUM_HS-1:0] O_BOOTSTRAP_INHIBIT_N,    // bootstrap switch inhibit, low active
  output logic      [NUM_HS-1:0] O_INIT_ACTIVE,            // initialization phase per driver
  output logic      [NUM_HS-1:0] O_BOOT_CUR_LIMIT,         // bootstrap current limit on
  output logic      [NUM_HS-1:0] O_SRC_THR_FORCED,         // source threshold forced
  output logic      [NUM_LS-1:0] O_LS_BIAS_EN,             // low-side biasing enable
  output logic      [NUM_HS-1:0] O_HS_BIAS_EN              // high-side biasing enable
);

  ////////////////////////////////////////////////////////////////////////////
  // association registers

  logic [DATA_W-1:0] assoc_12;
  logic [DATA_W-1:0] assoc_34;
  logic [DATA_W-1:0] assoc_5;
  logic [DATA_W-1:0] next_assoc_12;
  logic [DATA_W-1:0] next_assoc_34;
  logic [DATA_W-1:0] next_assoc_5;
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_assoc_12 = assoc_12;
    next_assoc_34 = assoc_34;
    next_assoc_5  = assoc_5;
    next_rdata    = O_REG_RDATA;
    if (I_REG.wr && I_REG.addr == ADDR_ASSOC_12) begin
      next_assoc_12 = I_REG.wdata & MASK_ASSOC_PAIR;
    end else if (I_REG.wr && I_REG.addr == ADDR_ASSOC_34) begin
      next_assoc_34 = I_REG.wdata & MASK_ASSOC_PAIR;
    end else if (I_REG.wr && I_REG.addr == ADDR_ASSOC_5) begin
      next_assoc_5 = I_REG.wdata & MASK_ASSOC_ONE;
    end
    if (I_REG.rd) begin
      if (I_REG.addr == ADDR_ASSOC_12) begin
        next_rdata = assoc_12;
      end else if (I_REG.addr == ADDR_ASSOC_34) begin
        next_rdata = assoc_34;
      end else if (I_REG.addr == ADDR_ASSOC_5) begin
        next_rdata = assoc_5;
      end else begin
        next_rdata = '0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      assoc_12    <= RST_ASSOC_PAIR;
      assoc_34    <= RST_ASSOC_PAIR;
      assoc_5     <= RST_ASSOC_ONE;
      O_REG_RDATA <= '0;
    end else begin
      assoc_12    <= next_assoc_12;
      assoc_34    <= next_assoc_34;
      assoc_5     <= next_assoc_5;
      O_REG_RDATA <= next_rdata;
    end
  end

  // low-side association of one high-side driver
  function automatic logic [NUM_LS-1:0] assoc_of(input int hs,
                                                 input logic [DATA_W-1:0] r12,
                                                 input logic [DATA_W-1:0] r34,
                                                 input logic [DATA_W-1:0] r5);
    logic [DATA_W-1:0] r;
    r = (hs < 2) ? r12 : ((hs < 4) ? r34 : r5);
    if (hs % 2 == 1) begin
      r = r >> ASSOC_HI_LSB;
    end
    return r[NUM_LS-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencing and source-limit window

  init_state_t          state;
  init_state_t          next_state;
  logic [NUM_HS-1:0]    init_active;
  logic [NUM_HS-1:0]    next_init_active;
  logic [WIN_CNT_W-1:0] win_cnt;
  logic [WIN_CNT_W-1:0] next_win_cnt;
  logic                 win_open;
  logic [NUM_HS-1:0]    src_ok;
  logic [NUM_HS-1:0]    term;
  logic [NUM_HS-1:0]    ls_hit;
  logic                 ls_any_on;

  assign win_open  = (win_cnt < WIN_CNT_W'(WIN_CYC));
  assign ls_any_on = |I_LS_ON;
  // tighter source limit only while the window after the supply crossing runs
  assign src_ok    = win_open ? I_SENSE.src_below_0v5 : I_SENSE.src_below_1v0;

  always_comb begin
    term   = '0;
    ls_hit = '0;
    for (int i = 0; i < NUM_HS; i++) begin
      ls_hit[i] = |(I_LS_ON & assoc_of(i, assoc_12, assoc_34, assoc_5));
      term[i] = (I_SENSE.boot_near_supply[i] & src_ok[i])
              | (I_SENSE.clamp_active[i] & src_ok[i])
              | ls_hit[i]
              | (assoc_of(i, assoc_12, assoc_34, assoc_5) == '0)
              | I_HS_ON[i];
    end
  end

  always_comb begin
    next_state       = state;
    next_init_active = init_active;
    next_win_cnt     = win_cnt;
    case (state)
      ST_WAIT: begin
        if (I_SUPPLY_UV_OK) begin
          next_state       = ST_INIT;
          next_init_active = '1;
          next_win_cnt     = '0;
        end
      end
      ST_INIT: begin
        if (win_open) begin
          next_win_cnt = win_cnt + WIN_CNT_W'(1);
        end
        // a flag once cleared is never set again in this state
        next_init_active = init_active & ~term;
        if (next_init_active == '0) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state       <= ST_WAIT;
      init_active <= '0;
      win_cnt     <= '0;
    end else begin
      state       <= next_state;
      init_active <= next_init_active;
      win_cnt     <= next_win_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered driver controls

  logic [NUM_HS-1:0] inhibit_cause;
  assign inhibit_cause = (init_active | I_INJ_END) & {NUM_HS{~ls_any_on}};

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_BOOTSTRAP_INHIBIT_N <= '0;
      O_INIT_ACTIVE         <= '0;
      O_BOOT_CUR_LIMIT      <= '0;
      O_SRC_THR_FORCED      <= '0;
      O_LS_BIAS_EN          <= '0;
      O_HS_BIAS_EN          <= '0;
    end else begin
      O_BOOTSTRAP_INHIBIT_N <= ~inhibit_cause;
      O_INIT_ACTIVE         <= init_active;
      O_BOOT_CUR_LIMIT      <= init_active;
      O_SRC_THR_FORCED      <= init_active;
      O_LS_BIAS_EN          <= (|init_active) ? '1 : I_LS_BIAS_REQ;
      O_HS_BIAS_EN          <= (|init_active) ? '0 : I_HS_BIAS_REQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int WIN_LAST = WIN_CYC - 1;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  sequence s_supply_rise;
    state == ST_WAIT && I_SUPPLY_UV_OK;
  endsequence

  sequence s_phase_on;
    init_active == '1 ##1 (O_LS_BIAS_EN == '1 && O_HS_BIAS_EN == '0);
  endsequence

  a_phase_start: assert property (s_supply_rise |=> s_phase_on)
    else $error("init phase did not start on supply rise");

  a_bias_forced: assert property (|init_active |=> O_LS_BIAS_EN == '1 && O_HS_BIAS_EN == '0
                                  && O_BOOT_CUR_LIMIT == $past(init_active))
    else $error("biasing not forced during init");

  a_inhibit_low: assert property ((|init_active && !ls_any_on)
                                  |=> (O_BOOTSTRAP_INHIBIT_N & $past(init_active)) == '0)
    else $error("bootstrap not inhibited during init");

  a_near_ends: assert property ((state == ST_INIT && win_open)
                                |-> ##1 (init_active & $past(I_SENSE.boot_near_supply
                                         & I_SENSE.src_below_0v5)) == '0)
    else $error("near-supply termination missed");

  a_clamp_late: assert property ((state == ST_INIT && !win_open)
                                 |=> (init_active & $past(I_SENSE.clamp_active
                                      & I_SENSE.src_below_1v0)) == '0)
    else $error("clamp termination after window missed");

  a_ls_on_ends: assert property ((state == ST_INIT && ls_hit != '0)
                                 |=> (init_active & $past(ls_hit)) == '0)
    else $error("associated low-side on did not end init");

  a_hs_on_ends: assert property ((state == ST_INIT && I_HS_ON != '0)
                                 |=> (init_active & $past(I_HS_ON)) == '0)
    else $error("high-side on did not end init");

  a_no_assoc: assert property ((state == ST_INIT && assoc_5 == '0)
                               |=> !init_active[NUM_HS-1])
    else $error("unassociated driver still initializing");

  a_no_restart: assert property ((state != ST_WAIT)
                                 |=> (init_active & ~$past(init_active)) == '0)
    else $error("init flag restarted without reset");

  a_window_end: assert property ((state == ST_INIT && win_cnt == WIN_CNT_W'(WIN_LAST))
                                 |=> !win_open ##1 !win_open)
    else $error("source limit window length wrong");

endmodule

/* tb/gate_circuit_model.sv */
// Purpose: behavioural high-side and low-side gate circuits around the drivers
// Assumes: a driver charges only while some low-side biasing is on
// Notes: charge takes four cycles; masks pick clamp or a raised source
`timescale 1ns/1ns
module gate_circuit_model
  import boot_init_pkg::*;
(
  input  wire logic              i_clk,     // core clock
  input  wire logic              i_rst,     // async reset
  input  wire logic [NUM_LS-1:0] i_ls_bias, // low-side biasing
  input  wire logic [NUM_HS-1:0] i_fast,    // drivers with a charge path
  input  wire logic [NUM_HS-1:0] i_clamp,   // charged driver shows clamp
  input  wire logic [NUM_HS-1:0] i_src_mid, // source between 0.5 V and 1.0 V
  output drv_sense_t             o_sense    // comparator levels
);
  logic [2:0] cnt [NUM_HS];
  ////////////////////////////////////////
  // no path, no charge: a driver without one never reports charged
  always_ff @(posedge i_clk or posedge i_rst) begin
    for (int i = 0; i < NUM_HS; i++) begin
      if (i_rst) begin
        cnt[i] <= 3'h0;
      end else if (|i_ls_bias && i_fast[i] && cnt[i] != 3'h4) begin
        cnt[i] <= cnt[i] + 3'h1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_HS; i++) begin
      o_sense.boot_near_supply[i] = (cnt[i] == 3'h4) && !i_clamp[i];
      o_sense.clamp_active[i]     = (cnt[i] == 3'h4) && i_clamp[i];
      o_sense.src_below_0v5[i]    = !i_src_mid[i];
      o_sense.src_below_1v0[i]    = 1'b1;
    end
  end
endmodule

/* tb/tb_bootstrap_init_control.sv */
// Purpose: self-checking bench for the bootstrap initialization control
// Assumes: short source window of 20 cycles
// Notes: expected values queued by the driver, compared on the falling edge
`timescale 1ns/1ns
module tb_bootstrap_init_control
  import boot_init_pkg::*;
;
  typedef struct packed {logic [2:0] sel; logic [15:0] val;} note_t;
  logic clk, rst, uv_ok;
  drv_sense_t sense;
  logic [NUM_LS-1:0] ls_on, ls_req, ls_bias;
  logic [NUM_HS-1:0] hs_on, inj_end, hs_req, inh_n, init_act, cur_lim, thr_f, hs_bias;
  logic [NUM_HS-1:0] fast, clamp, src_mid;
  reg_req_t reg_q;
  logic [DATA_W-1:0] rdata, d;
  logic [ADDR_W-1:0] a;
  note_t exp_q[$];
  note_t n;
  int miscompares, total_checks, seed;

  bootstrap_init_control #(.WIN_CYC(20)) dut (
    .I_CLK_SYS(clk), .I_RST(rst), .I_SUPPLY_UV_OK(uv_ok), .I_SENSE(sense),
    .I_LS_ON(ls_on), .I_HS_ON(hs_on), .I_INJ_END(inj_end), .I_LS_BIAS_REQ(ls_req),
    .I_HS_BIAS_REQ(hs_req), .I_REG(reg_q), .O_REG_RDATA(rdata),
    .O_BOOTSTRAP_INHIBIT_N(inh_n), .O_INIT_ACTIVE(init_act), .O_BOOT_CUR_LIMIT(cur_lim),
    .O_SRC_THR_FORCED(thr_f), .O_LS_BIAS_EN(ls_bias), .O_HS_BIAS_EN(hs_bias));

  gate_circuit_model partner (
    .i_clk(clk), .i_rst(rst), .i_ls_bias(ls_bias), .i_fast(fast),
    .i_clamp(clamp), .i_src_mid(src_mid), .o_sense(sense));
  ////////////////////////////////////////
  function logic [15:0] probe(input logic [2:0] sel);
    case (sel)
      3'h0: probe = rdata;
      3'h1: probe = {11'h0, init_act};
      3'h2: probe = {11'h0, inh_n};
      3'h3: probe = {9'h0, ls_bias};
      3'h4: probe = {11'h0, hs_bias};
      3'h5: probe = {11'h0, cur_lim};
      default: probe = {11'h0, thr_f};
    endcase
  endfunction
  task expect_out(input logic [2:0] sel, input logic [15:0] val);
    exp_q.push_back(note_t'{sel, val});
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task wr(input logic [9:0] ad, input logic [15:0] dt);
    reg_q <= '{1'b1, 1'b0, ad, dt};
    tick(1);
    reg_q <= '0;
    tick(1);
  endtask
  // read data is registered and held, so the note is queued one edge after it lands
  task rd(input logic [9:0] ad, input logic [15:0] ex);
    reg_q <= '{1'b0, 1'b1, ad, 16'h0};
    tick(1);
    reg_q <= '0;
    tick(1);
    expect_out(3'h0, ex);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  always @(negedge clk) begin
    while (exp_q.size() > 0) begin
      n = exp_q.pop_front();
      total_checks++;
      if (probe(n.sel) !== n.val) begin
        miscompares++;
        $display("ERROR t=%0t sel %0d got %h exp %h", $time, n.sel, probe(n.sel), n.val);
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    tick(2000);
    miscompares++;
    $display("ERROR t=%0t run did not finish got %h exp %h", $time, 1'b0, 1'b1);
    test_done;
  end
  initial begin
    rst = 1'b1; uv_ok = 1'b0; ls_on = '0; hs_on = '0; inj_end = '0;
    ls_req = '0; hs_req = '0; reg_q = '0; seed = 31;
    fast = 5'h13; clamp = 5'h02; src_mid = 5'h10;
    tick(3);
    expect_out(3'h2, 16'h0);
    tick(2);
    rst <= 1'b0;
    tick(1);
    rd(ADDR_ASSOC_12, RST_ASSOC_PAIR);
    rd(ADDR_ASSOC_34, RST_ASSOC_PAIR);
    rd(ADDR_ASSOC_5, RST_ASSOC_ONE);
    for (int i = 0; i < 8; i++) begin
      a = 10'h1a6 + 10'(i % 4);
      d = 16'($random(seed));
      wr(a, d);
      rd(a, a == 10'h1a9 ? 16'h0 : a == 10'h1a8 ? d & MASK_ASSOC_ONE : d & MASK_ASSOC_PAIR);
    end
    $display("test registers done");
    // one low-side per driver, none shared, so no blanking is owed
    wr(ADDR_ASSOC_12, 16'h0201);
    wr(ADDR_ASSOC_34, 16'h0804);
    wr(ADDR_ASSOC_5, 16'h0010);
    ls_req <= 7'($random(seed));
    hs_req <= 5'($random(seed));
    uv_ok <= 1'b1;
    tick(2);
    expect_out(3'h1, 16'h1f);
    expect_out(3'h5, 16'h1f);
    expect_out(3'h6, 16'h1f);
    expect_out(3'h3, 16'h7f);
    expect_out(3'h4, 16'h0);
    expect_out(3'h2, 16'h0);
    ls_on <= 7'h04;
    tick(8);
    expect_out(3'h1, 16'h18);
    hs_on <= 5'h08;
    tick(4);
    expect_out(3'h1, 16'h10);
    expect_out(3'h3, 16'h7f);
    tick(12);
    expect_out(3'h1, 16'h0);
    expect_out(3'h3, {9'h0, ls_req});
    expect_out(3'h4, {11'h0, hs_req});
    expect_out(3'h5, 16'h0);
    expect_out(3'h6, 16'h0);
    $display("test init phase done");
    ls_on <= 7'h0;
    hs_on <= 5'h0;
    inj_end <= 5'h15;
    tick(2);
    expect_out(3'h2, 16'h0a);
    ls_on <= 7'h40;
    tick(2);
    expect_out(3'h2, 16'h1f);
    uv_ok <= 1'b0;
    tick(2);
    uv_ok <= 1'b1;
    tick(4);
    expect_out(3'h1, 16'h0);
    $display("test inhibit and no restart done");
    rst <= 1'b1;
    uv_ok <= 1'b0;
    tick(2);
    rst <= 1'b0;
    tick(1);
    // unused drivers: every association cleared before start
    wr(ADDR_ASSOC_12, 16'h0);
    wr(ADDR_ASSOC_34, 16'h0);
    wr(ADDR_ASSOC_5, 16'h0);
    uv_ok <= 1'b1;
    tick(2);
    expect_out(3'h1, 16'h1f);
    tick(2);
    expect_out(3'h1, 16'h0);
    tick(1);
    $display("test cleared association done");
    test_done;
  end
endmodule
